//--- hw/hpi_host_port.sv
// host port block: host pins to dual access ram, apb control, reset stretch
// Notes on behaviour
// - strap low at reset: non-multiplexed, 16-bit address and data
// - strap high at reset: multiplexed with 8-bit data path
// - non-multiplexed: address pins 17..2 give address, data pins 15..0 data
// - non-multiplexed: external memory interface held disabled
// - multiplexed: byte pins are data, control pins are address/data select and half select
// - multiplexed: eight bits per bus cycle, two bytes per word
// - multiplexed: external memory interface stays enabled
// - only internal ram reachable; register and external spaces blocked
// - no ram access while device held in reset
// - addresses select 16-bit words, not bytes
// - 16-bit address register with optional autoincrement
// - host ready output handshakes every transfer
// - host-to-processor bit does not wake an idle processor
// - processor-to-host interrupt only from control register bit
// - stretch reset by counter, then acknowledge low two cycles
// - boot ready pin tells host that accesses are accepted
`timescale 1ns/100ps
module hpi_host_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        mode_strap_pin,
    input  wire logic [17:2] par_addr_pins,
    input  wire logic [15:0] par_data_in,
    output logic      [15:0] par_data_out,
    output logic             par_data_oe_n,
    input  wire logic        first_host_control_pin,
    input  wire logic        second_host_control_pin,
    input  wire logic        host_port_enable_pin,
    input  wire logic        host_chip_select_n,
    input  wire logic        first_host_data_strobe_n,
    input  wire logic        second_host_data_strobe_n,
    input  wire logic        host_rw,
    input  wire logic        processor_idle,
    output logic             host_ready_output,
    output logic             host_int_n,
    output logic             h2p_wake,
    output logic             ext_mem_enable,
    output logic             interrupt_acknowledge_output_n,
    output logic             boot_ready_pin,
    output logic             mux_mode
);
    // pin synchronisers: stage one read only by stage two
    localparam int SYN_W = 16 + 16 + 8;
    logic [SYN_W-1:0] syn1_r;
    logic [SYN_W-1:0] syn2_r;
    wire  [SYN_W-1:0] syn_in = {par_addr_pins, par_data_in, mode_strap_pin,
                                first_host_control_pin, second_host_control_pin,
                                host_port_enable_pin, host_chip_select_n,
                                first_host_data_strobe_n, second_host_data_strobe_n,
                                host_rw};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            syn1_r <= '0;
            syn2_r <= '0;
        end
        else
        begin
            syn1_r <= syn_in;
            syn2_r <= syn1_r;
        end
    end
    wire [15:0] s_addr   = syn2_r[39:24];
    wire [15:0] s_data   = syn2_r[23:8];
    wire        s_strap  = syn2_r[7];
    wire        s_ctl_a  = syn2_r[6];
    wire        s_ctl_b  = syn2_r[5];
    wire        s_ena    = syn2_r[4];
    wire        s_cs_n   = syn2_r[3];
    wire        s_ds_n   = syn2_r[2] & syn2_r[1];
    wire        s_rw     = syn2_r[0];

    // reset stretch counter; internal reset held until it expires
    logic [6:0] stretch_r;
    logic [1:0] ack_r;
    logic       run_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stretch_r <= '0;
            run_r     <= 1'b0;
            ack_r     <= '0;
        end
        else
        begin
            if (!run_r && stretch_r == 7'(hpi_pkg::STRETCH_CYC - 1))
            begin
                run_r <= 1'b1;
                ack_r <= 2'(hpi_pkg::ACK_CYC);
            end
            else if (!run_r)
                stretch_r <= stretch_r + 7'h01;
            else if (ack_r != 2'h0)
                ack_r <= ack_r - 2'h1;
        end
    end

    // strap captured as the stretched reset ends, clocked not async
    logic mux_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mux_r <= 1'b0;
        else if (!run_r)
            mux_r <= s_strap;
    end

    // control and interrupt registers
    logic [3:0]  ctrl_r;
    logic [2:0]  stat_r;
    logic [2:0]  mask_r;
    logic [15:0] addr_r;
    wire  apb_wr = psel && penable && pwrite;
    wire  apb_rd = psel && penable && !pwrite;

    // host side access state
    hpi_pkg::hpi_state_t st_r;
    logic [7:0]  lo_byte_r;
    logic [15:0] rd_word_r;
    logic        strobe_d_r;
    logic        is_wr_r;
    logic        inc_r;
    logic        ev_wr;
    logic        ev_rd;
    logic        ev_h2p;
    logic        host_addr_ld;
    logic [15:0] host_addr_val;
    logic        h2p_set;

    // word ram, only the internal array is reachable
    logic [hpi_pkg::WORD_W-1:0] ram [0:(1<<hpi_pkg::RAM_AW)-1];
    wire  [hpi_pkg::RAM_AW-1:0] ram_idx = addr_r[hpi_pkg::RAM_AW-1:0];
    wire  in_ram = (addr_r[15:hpi_pkg::RAM_AW] == '0);

    wire active = run_r && s_ena && !s_cs_n && !ctrl_r[hpi_pkg::CTRL_IDLE];
    wire strobe = active && !s_ds_n;
    wire start  = strobe && !strobe_d_r;
    // in mux mode first control pin selects address (high) or data (low), second is half select
    wire [1:0] hcode = mux_r ? {s_ctl_a, !s_ctl_a} : {s_ctl_b, s_ctl_a};
    wire half2 = s_ctl_b;

    // host transfer sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= hpi_pkg::HPI_IDLE;
            strobe_d_r <= 1'b0;
            lo_byte_r  <= '0;
            rd_word_r  <= '0;
            is_wr_r    <= 1'b0;
            inc_r      <= 1'b0;
        end
        else
        begin
            strobe_d_r <= strobe;
            unique case (st_r)
                hpi_pkg::HPI_IDLE:
                    if (start)
                    begin
                        is_wr_r <= !s_rw;
                        inc_r   <= ctrl_r[hpi_pkg::CTRL_AUTOINC]
                                   || (!mux_r && hcode == hpi_pkg::HC_DATA_INC);
                        st_r    <= hpi_pkg::HPI_DO;
                    end
                hpi_pkg::HPI_DO:
                begin
                    rd_word_r <= in_ram ? ram[ram_idx] : 16'h0000;
                    st_r      <= hpi_pkg::HPI_DONE;
                    if (mux_r && !half2 && is_wr_r)
                        lo_byte_r <= s_data[7:0];
                end
                hpi_pkg::HPI_DONE:
                    if (!strobe)
                        st_r <= hpi_pkg::HPI_IDLE;
            endcase
        end
    end

    // word is committed on the second half only in mux mode
    wire data_cyc = (hcode == hpi_pkg::HC_DATA) || (hcode == hpi_pkg::HC_DATA_INC);
    wire commit   = (st_r == hpi_pkg::HPI_DO) && data_cyc && (!mux_r || half2);
    wire [15:0] wr_word = mux_r ? {s_data[7:0], lo_byte_r} : s_data;
    always_ff @(posedge pclk)
    begin
        if (commit && is_wr_r && in_ram && run_r)
            ram[ram_idx] <= wr_word;
    end

    // host events and address load decoding
    always_comb
    begin
        ev_wr         = commit && is_wr_r;
        ev_rd         = commit && !is_wr_r;
        host_addr_ld  = (st_r == hpi_pkg::HPI_DO) && is_wr_r && (hcode == hpi_pkg::HC_ADDR);
        // non-mux takes the address pins; mux loads one byte per half
        host_addr_val = s_addr;
        if (mux_r)
            host_addr_val = half2 ? {s_data[7:0], addr_r[7:0]} : {addr_r[15:8], s_data[7:0]};
        h2p_set       = (st_r == hpi_pkg::HPI_DO) && is_wr_r && (hcode == hpi_pkg::HC_CTRL)
                        && s_data[hpi_pkg::CTRL_H2P];
        ev_h2p        = h2p_set;
    end

    // address register with autoincrement after a data word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            addr_r <= '0;
        else if (host_addr_ld)
            addr_r <= host_addr_val;
        else if (apb_wr && paddr == hpi_pkg::OFS_ADDR)
            addr_r <= pwdata[15:0];
        else if (commit && inc_r)
            addr_r <= addr_r + 16'h0001;
    end

    // control register: processor writes, host may set the h2p bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= '0;
        else if (apb_wr && paddr == hpi_pkg::OFS_CTRL)
            ctrl_r <= pwdata[3:0] | {3'h0, h2p_set};
        else if (h2p_set)
            ctrl_r[hpi_pkg::CTRL_H2P] <= 1'b1;
    end

    // sticky status, read clears, a new event wins over the clear
    wire [2:0] ev_vec = {ev_rd, ev_wr, ev_h2p};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_r <= '0;
        else if (apb_rd && paddr == hpi_pkg::OFS_STAT)
            // clear only what was reported; an event after the setup edge survives
            stat_r <= (stat_r & ~prdata[2:0]) | ev_vec;
        else
            stat_r <= stat_r | ev_vec;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= '0;
        else if (apb_wr && paddr == hpi_pkg::OFS_MASK)
            mask_r <= pwdata[2:0];
    end

    // apb slave: zero wait, unmapped reads zero with error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable)
                unique case (paddr)
                    hpi_pkg::OFS_CTRL: prdata <= {28'h0, ctrl_r};
                    hpi_pkg::OFS_STAT: prdata <= {29'h0, stat_r};
                    hpi_pkg::OFS_MASK: prdata <= {29'h0, mask_r};
                    hpi_pkg::OFS_ADDR: prdata <= {16'h0, addr_r};
                    default:           pslverr <= 1'b1;
                endcase
        end
    end

    // pin side outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq                            <= 1'b0;
            host_ready_output              <= 1'b0;
            host_int_n                     <= 1'b1;
            h2p_wake                       <= 1'b0;
            ext_mem_enable                 <= 1'b0;
            interrupt_acknowledge_output_n <= 1'b1;
            boot_ready_pin                 <= 1'b0;
            mux_mode                       <= 1'b0;
            par_data_out                   <= '0;
            par_data_oe_n                  <= 1'b1;
        end
        else
        begin
            irq  <= |(stat_r & mask_r);
            host_ready_output <= run_r && (st_r == hpi_pkg::HPI_IDLE);
            host_int_n <= !ctrl_r[hpi_pkg::CTRL_P2H];
            h2p_wake <= ctrl_r[hpi_pkg::CTRL_H2P] && !processor_idle;
            ext_mem_enable <= run_r && mux_r;
            interrupt_acknowledge_output_n <= (ack_r == 2'h0);
            boot_ready_pin <= run_r;
            mux_mode <= mux_r;
            par_data_out <= mux_r ? (half2 ? {8'h00, rd_word_r[15:8]}
                                           : {8'h00, rd_word_r[7:0]}) : rd_word_r;
            par_data_oe_n <= !(strobe && !is_wr_r && st_r == hpi_pkg::HPI_DONE);
        end
    end

    // assertions
    a_ack_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(interrupt_acknowledge_output_n) |=> !interrupt_acknowledge_output_n
        ##1 interrupt_acknowledge_output_n)
        else $error("ack pulse not two cycles");
    a_xmem_off: assert property (@(posedge pclk) disable iff (!presetn)
        run_r && !mux_r |=> !ext_mem_enable)
        else $error("external memory enabled in non-mux mode");
    a_xmem_on: assert property (@(posedge pclk) disable iff (!presetn)
        run_r && mux_r |=> ext_mem_enable)
        else $error("external memory off in mux mode");
    a_no_reset_wr: assert property (@(posedge pclk) disable iff (!presetn)
        !run_r |-> !commit)
        else $error("ram access during reset");
    a_ready_busy: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == hpi_pkg::HPI_DO |=> !host_ready_output)
        else $error("ready during access");
    a_addr_inc: assert property (@(posedge pclk) disable iff (!presetn)
        commit && inc_r && !host_addr_ld && !apb_wr |=> addr_r == $past(addr_r) + 16'h0001)
        else $error("address not incremented");
    a_boot_ready: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(run_r) |=> boot_ready_pin)
        else $error("boot ready late");
    a_p2h_pin: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[hpi_pkg::CTRL_P2H] |=> !host_int_n)
        else $error("host interrupt missing");
    a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
        processor_idle |=> !h2p_wake)
        else $error("idle processor woken");
    a_mux_low: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == hpi_pkg::HPI_DO && mux_r && is_wr_r && !half2
        |=> lo_byte_r == $past(s_data[7:0]))
        else $error("mux low byte not held");
    c_write: cover property (@(posedge pclk) ev_wr);
    c_read: cover property (@(posedge pclk) ev_rd);
    c_mux: cover property (@(posedge pclk) commit && mux_r);
    c_irq: cover property (@(posedge pclk) irq);
endmodule : hpi_host_port

//--- hw/hpi_pkg.sv
// package for the host port block: modes, widths, timing constants
package hpi_pkg;
    localparam int          WORD_W       = 16;
    localparam int          BYTE_W       = 8;
    localparam int          ADDR_W       = 16;
    localparam int          RAM_AW       = 10;
    localparam int          APB_AW       = 12;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STAT     = 12'h004;
    localparam logic [11:0] OFS_MASK     = 12'h008;
    localparam logic [11:0] OFS_ADDR     = 12'h00C;
    // control bit positions
    localparam int          CTRL_H2P     = 0;
    localparam int          CTRL_P2H     = 1;
    localparam int          CTRL_IDLE    = 2;
    localparam int          CTRL_AUTOINC = 3;
    // status bit positions
    localparam int          ST_H2P       = 0;
    localparam int          ST_WRDONE    = 1;
    localparam int          ST_RDDONE    = 2;
    localparam int          ST_W         = 3;
    // reset stretch and acknowledge pulse
    localparam int          STRETCH_CYC  = 64;
    localparam int          ACK_CYC      = 2;
    // host control codes on the two control pins (non-multiplexed)
    localparam logic [1:0]  HC_CTRL      = 2'h0;
    localparam logic [1:0]  HC_DATA_INC  = 2'h1;
    localparam logic [1:0]  HC_ADDR      = 2'h2;
    localparam logic [1:0]  HC_DATA      = 2'h3;
    typedef enum logic [1:0] {HPI_IDLE, HPI_DO, HPI_DONE} hpi_state_t;
endpackage : hpi_pkg

//--- tb/hpi_host_model.sv
// host-side model: drives address, data, codes and strobes of the host port
`timescale 1ns/100ps
module hpi_host_model (
    input  wire logic        pclk,
    input  wire logic [15:0] par_data_out,
    input  wire logic        host_ready_output,
    output logic      [17:2] par_addr_pins,
    output logic      [15:0] par_data_in,
    output logic             first_host_control_pin,
    output logic             second_host_control_pin,
    output logic             host_port_enable_pin,
    output logic             host_chip_select_n,
    output logic             first_host_data_strobe_n,
    output logic             second_host_data_strobe_n,
    output logic             host_rw,
    output logic             got,
    output logic      [15:0] got_data,
    output logic             hang
);
    // port disabled and strobes idle until the bench starts traffic
    initial
    begin
        host_port_enable_pin = 1'b0;
        {host_chip_select_n, first_host_data_strobe_n, second_host_data_strobe_n} = 3'h7;
        {host_rw, first_host_control_pin, second_host_control_pin} = 3'h4;
        par_addr_pins = 16'h0000;
        par_data_in = 16'hFFFF;
        {got, got_data, hang} = 18'h00000;
    end

    // bounded wait for a ready level; a hang is flagged to the bench
    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (host_ready_output !== lvl && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) hang <= 1'b1;
    endtask : wait_rdy

    // one strobed transfer; a byte in multiplexed mode, a word otherwise
    task automatic xfer(input logic hc1, input logic hc0, input logic rd,
                        input logic [15:0] adr, input logic [15:0] dat);
        wait_rdy(1'b1);
        @(posedge pclk);
        host_port_enable_pin <= 1'b1;
        host_chip_select_n <= 1'b0;
        {second_host_control_pin, first_host_control_pin, host_rw} <= {hc1, hc0, rd};
        par_addr_pins <= adr;
        par_data_in <= dat;
        {first_host_data_strobe_n, second_host_data_strobe_n} <= 2'h0;
        wait_rdy(1'b0);
        // read data is launched at the edge where ready is seen low; take it one edge on
        @(posedge pclk);
        got_data <= par_data_out;
        got <= rd;
        @(posedge pclk);
        got <= 1'b0;
        // released lines show the inverse, never a stale copy
        {host_chip_select_n, first_host_data_strobe_n, second_host_data_strobe_n} <= 3'h7;
        par_data_in <= ~dat;
        par_addr_pins <= ~adr;
        wait_rdy(1'b1);
    endtask : xfer
endmodule : hpi_host_model

//--- tb/testbench.sv
// self-checking bench for the host port block: apb side plus host model
`timescale 1ns/100ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, mode_strap_pin, processor_idle;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, res, exp, d;
    logic        pready, pslverr, irq, err, got, hang;
    logic [15:0] par_addr_pins, par_data_in, par_data_out, got_data;
    logic        ctl_a, ctl_b, ena, cs_n, ds1_n, ds2_n, host_rw, rdy, oe_n;
    logic        host_int_n, h2p_wake, ext_mem_enable, ack_n, boot_ready_pin, mux_mode;
    logic [31:0] expq[$];
    int          n_fail = 0;
    int          n_tests = 0;

    hpi_host_port hpi_host_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .mode_strap_pin(mode_strap_pin),
        .par_addr_pins(par_addr_pins), .par_data_in(par_data_in), .par_data_out(par_data_out),
        .par_data_oe_n(oe_n), .first_host_control_pin(ctl_a), .second_host_control_pin(ctl_b),
        .host_port_enable_pin(ena), .host_chip_select_n(cs_n), .first_host_data_strobe_n(ds1_n),
        .second_host_data_strobe_n(ds2_n), .host_rw(host_rw), .processor_idle(processor_idle),
        .host_ready_output(rdy), .host_int_n(host_int_n), .h2p_wake(h2p_wake),
        .ext_mem_enable(ext_mem_enable), .interrupt_acknowledge_output_n(ack_n),
        .boot_ready_pin(boot_ready_pin), .mux_mode(mux_mode));

    hpi_host_model hpi_host_model_i (.pclk(pclk), .par_data_out(par_data_out),
        .host_ready_output(rdy), .par_addr_pins(par_addr_pins), .par_data_in(par_data_in),
        .first_host_control_pin(ctl_a), .second_host_control_pin(ctl_b),
        .host_port_enable_pin(ena),
        .host_chip_select_n(cs_n), .first_host_data_strobe_n(ds1_n),
        .second_host_data_strobe_n(ds2_n), .host_rw(host_rw), .got(got),
        .got_data(got_data), .hang(hang));

    // 4 ns clock
    always #2 pclk = ~pclk;

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // a used-up bound is a mismatch and ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            n_fail++;
            complete_run();
        end
    endtask : bound

    // apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        bound(n, 20);
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // reset with a strap level, then follow the stretch and acknowledge pulse
    task automatic boot(input logic strap);
        int n;
        @(posedge pclk);
        {presetn, mode_strap_pin} <= {1'b0, strap};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(boot_ready_pin, 1'b0);
        n = 1;
        while (ack_n !== 1'b0 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        bound(n, 200);
        chk(n >= hpi_pkg::STRETCH_CYC - 1, 1'b1);
        n = 0;
        while (ack_n === 1'b0 && n < 10)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n, hpi_pkg::ACK_CYC);
        repeat (3) @(posedge pclk);
        chk(boot_ready_pin, 1'b1);
        $display("test boot done");
    endtask : boot

    // results are matched in order against the oldest expectation
    always @(posedge pclk)
    begin
        if ((psel && penable && pready && !pwrite) || got)
        begin
            res = got ? {16'h0000, mux_mode ? {8'h00, got_data[7:0]} : got_data} : prdata;
            exp = (expq.size() > 0) ? expq.pop_front() : ~res;
            chk(res, exp);
            if (got)
                chk(oe_n, 1'b0);
        end
    end

    always @(posedge hang)
    begin
        n_fail++;
        complete_run();
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {mode_strap_pin, processor_idle} = 2'h0;
        void'($urandom(32'h0BB9));
        boot(1'b0);
        chk(mux_mode, 1'b0);
        chk(ext_mem_enable, 1'b0);
        rd(hpi_pkg::OFS_CTRL, 32'h0);
        rd(12'h010, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, hpi_pkg::OFS_CTRL, 32'h8);
        apb(1'b1, hpi_pkg::OFS_MASK, 32'h7);
        d = $urandom;
        hpi_host_model_i.xfer(1'b1, 1'b0, 1'b0, 16'h03FF, 16'h0);
        hpi_host_model_i.xfer(1'b0, 1'b1, 1'b0, 16'h0, d[15:0]);
        hpi_host_model_i.xfer(1'b0, 1'b1, 1'b0, 16'h0, d[31:16]);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        rd(hpi_pkg::OFS_STAT, 32'h2);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        hpi_host_model_i.xfer(1'b1, 1'b0, 1'b0, 16'h03FF, 16'h0);
        expq.push_back({16'h0, d[15:0]});
        hpi_host_model_i.xfer(1'b0, 1'b1, 1'b1, 16'h0, 16'h0);
        expq.push_back(32'h0);
        hpi_host_model_i.xfer(1'b0, 1'b1, 1'b1, 16'h0, 16'h0);
        $display("test word traffic done");
        apb(1'b1, hpi_pkg::OFS_CTRL, 32'hA);
        repeat (3) @(posedge pclk);
        chk(host_int_n, 1'b0);
        processor_idle <= 1'b1;
        hpi_host_model_i.xfer(1'b0, 1'b0, 1'b0, 16'h0, 16'h0001);
        repeat (4) @(posedge pclk);
        chk(h2p_wake, 1'b0);
        processor_idle <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(h2p_wake, 1'b1);
        $display("test interrupts done");
        boot(1'b1);
        chk(mux_mode, 1'b1);
        chk(ext_mem_enable, 1'b1);
        d = $urandom;
        for (int k = 0; k < 2; k++)
        begin
            hpi_host_model_i.xfer(1'b0, 1'b1, 1'b0, 16'h0, 16'h0021);
            hpi_host_model_i.xfer(1'b1, 1'b1, 1'b0, 16'h0, 16'h0000);
            if (k == 1) expq.push_back({24'h0, d[7:0]});
            hpi_host_model_i.xfer(1'b0, 1'b0, k[0], 16'h0, {8'h00, d[7:0]});
            if (k == 1) expq.push_back({24'h0, d[15:8]});
            hpi_host_model_i.xfer(1'b1, 1'b0, k[0], 16'h0, {8'h00, d[15:8]});
        end
        $display("test byte traffic done");
        repeat (5) @(posedge pclk);
        chk(expq.size(), 32'h0);
        complete_run();
    end
endmodule : testbench
